// ---- verif/ast_remote.sv ----
// remote serial end: sends frames on rxd and decodes frames seen on txd
// assumes bit_cyc holds the bit time in pclk cycles
`timescale 1ns/10ps
module ast_remote (
  input wire logic pclk,
  input wire logic txd,
  input var  int   bit_cyc,
  output logic     rxd
);
  logic [8:0] got;
  int         n_got;
  initial begin
    rxd = 1'b1;
    n_got = 0;
  end
  // start low, data lsb first, parity or stop, stop; line idles high
  task automatic send(input logic [7:0] b, input logic pe, input logic ev, input logic stp);
    logic [10:0] f;
    f = pe ? {stp, ^b ^ ~ev, b, 1'b0} : {1'b1, stp, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // sample mid-bit: 8 data bits then the bit after them
  initial forever begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge pclk);
      got[i] = txd;
    end
    n_got++;
  end
endmodule

// ---- verif/ast_uart_chk.sv ----
// concurrent checks on the apb and serial ports of the transceiver
// assumes one clock pclk and an async active-low presetn
`timescale 1ns/10ps
module ast_uart_chk
  import ast_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ast_pkg::AST_AW-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        rxd_in,
  input wire logic                        timer_tick,
  input wire logic                        txd,
  input wire logic                        tx_event_irq,
  input wire logic                        rx_event_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = (paddr == AST_ADDR_STATUS) || (paddr == AST_ADDR_CTRL) ||
                (paddr == AST_ADDR_DATA);

  chk_ready_timing: assert property (psel && penable && !pready |=> pready)
    else $error("pready did not follow the access phase");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside a request or longer than one cycle");
  chk_unmapped_err: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without pslverr");
  chk_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside the answer cycle");
  chk_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("prdata upper bits not zero");
  chk_txirq_start: assert property (tx_event_irq |=> (!txd && !tx_event_irq) [*8])
    else $error("transmit event without start bit or not a pulse");
  chk_txd_bitlen: assert property ($fell(txd) |-> !txd [*8])
    else $error("serial output low level too short");
  chk_rxirq_pulse: assert property (rx_event_irq |=> !rx_event_irq)
    else $error("receive event longer than one cycle");
endmodule

bind ast_uart ast_uart_chk i_ast_uart_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .timer_tick(timer_tick), .txd(txd),
  .tx_event_irq(tx_event_irq), .rx_event_irq(rx_event_irq));

// ---- verif/testbench.sv ----
// self-checking bench: apb register access plus a remote serial end
// assumes the design answers apb in two access cycles
`timescale 1ns/10ps
module testbench;
  import ast_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, es;
  logic              rxd_in, timer_tick, txd, tx_event_irq, rx_event_irq, pready, pslverr;
  logic [AST_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  int                failures, num_checks, cyc, bit_cyc, tc;

  ast_uart i_ast_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_in(rxd_in), .timer_tick(timer_tick), .txd(txd),
    .tx_event_irq(tx_event_irq), .rx_event_irq(rx_event_irq));
  ast_remote i_ast_remote (.pclk(pclk), .txd(txd), .bit_cyc(bit_cyc), .rxd(rxd_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // timer pulse every 7 cycles; run ceiling
  always @(posedge pclk) begin
    tc <= (tc == 6) ? 0 : tc + 1;
    timer_tick <= (tc == 0);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      end_sim();
    end
  end

  task automatic apb(input logic wr, input logic [AST_AW-1:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    es = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic st(input logic [7:0] e);
    apb(1'b0, AST_ADDR_STATUS, 8'h00);
    chk(e, rd[7:0]);
  endtask
  task automatic wt(input int n);
    int k;
    k = 0;
    while (i_ast_remote.n_got < n && k < 30000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 30000) failures++;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, timer_tick} = '0;
    {failures, num_checks, cyc, tc} = '0;
    bit_cyc = 208;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    st(8'h0C);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    chk(8'h00, rd[7:0]);
    apb(1'b1, 10'h100, 8'h55);
    chk(8'h01, {7'h00, es});
    apb(1'b1, AST_ADDR_DATA, 8'h00);
    st(8'h0C);
    apb(1'b1, AST_ADDR_DATA, 8'h00);
    $display("reset and map done");
    apb(1'b1, AST_ADDR_CTRL, 8'h80);
    repeat (20) @(posedge pclk);
    chk(8'h01, {7'h00, txd});
    apb(1'b1, AST_ADDR_DATA, 8'h5A);
    st(8'h0C);
    repeat (3000) @(posedge pclk);
    chk(8'h00, i_ast_remote.n_got[7:0]);
    apb(1'b1, AST_ADDR_DATA, 8'hA5);
    wt(1);
    chk(8'hA5, i_ast_remote.got[7:0]);
    st(8'h04);
    repeat (2 * bit_cyc) @(posedge pclk);
    st(8'h0C);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, AST_ADDR_CTRL, 8'h88 | (e[7:0] << 4) | (e[7:0] << 5));
      st(8'h0C);
      apb(1'b1, AST_ADDR_DATA, 8'h07);
      wt(2 + e);
      chk({7'h00, e[0]}, {7'h00, i_ast_remote.got[8]});
      repeat (2 * bit_cyc) @(posedge pclk);
      st(e ? 8'h04 : 8'h0C);
      repeat (2 * bit_cyc) @(posedge pclk);
    end
    $display("transmit done");
    apb(1'b1, AST_ADDR_CTRL, 8'h40);
    i_ast_remote.send(8'h3C, 1'b0, 1'b0, 1'b1);
    st(8'h1C);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    chk(8'h3C, rd[7:0]);
    st(8'h0C);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    chk(8'h3C, rd[7:0]);
    i_ast_remote.send(8'h11, 1'b0, 1'b0, 1'b1);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    st(8'h1C);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    i_ast_remote.send(8'h22, 1'b0, 1'b0, 1'b1);
    i_ast_remote.send(8'h33, 1'b0, 1'b0, 1'b1);
    st(8'h3C);
    i_ast_remote.send(8'h44, 1'b0, 1'b0, 1'b1);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    chk(8'h22, rd[7:0]);
    st(8'h0C);
    apb(1'b1, AST_ADDR_CTRL, 8'h58);
    i_ast_remote.send(8'h07, 1'b1, 1'b0, 1'b1);
    st(8'h9C);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    i_ast_remote.send(8'h12, 1'b1, 1'b1, 1'b0);
    st(8'h5C);
    apb(1'b0, AST_ADDR_DATA, 8'h00);
    $display("receive done");
    for (int k = 0; k < 2; k++) begin
      bit_cyc = k ? 1536 : 112;
      apb(1'b1, AST_ADDR_CTRL, 8'h00);
      apb(1'b1, AST_ADDR_CTRL, k ? 8'h87 : 8'h86);
      st(8'h0C);
      apb(1'b1, AST_ADDR_DATA, 8'hC3);
      wt(4 + k);
      chk(8'hC3, i_ast_remote.got[7:0]);
      repeat (2 * bit_cyc) @(posedge pclk);
    end
    $display("rate sources done");
    end_sim();
  end
endmodule

// ---- verilog/ast_pkg.sv ----
// constants for the asynchronous serial transceiver: register map, field layout,
// reset values and the transfer clock divisors
// assumes a 32-bit apb with byte addresses and the system clock on pclk
package ast_pkg;
  // printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0] AST_IDX_STATUS = 8'h20;
  localparam logic [7:0] AST_IDX_CTRL   = 8'h21;
  localparam logic [7:0] AST_IDX_DATA   = 8'h22;
  localparam int         AST_AW         = 10;
  localparam logic [AST_AW-1:0] AST_ADDR_STATUS = {AST_IDX_STATUS, 2'b00};
  localparam logic [AST_AW-1:0] AST_ADDR_CTRL   = {AST_IDX_CTRL, 2'b00};
  localparam logic [AST_AW-1:0] AST_ADDR_DATA   = {AST_IDX_DATA, 2'b00};

  // line_control_register fields
  localparam int AST_CTL_TXE  = 7;
  localparam int AST_CTL_RXE  = 6;
  localparam int AST_CTL_STOP_LENGTH_SELECT = 5;
  localparam int AST_CTL_EVEN = 4;
  localparam int AST_CTL_PE   = 3;
  localparam int AST_CTL_BRG  = 0;
  localparam logic [7:0] AST_CTL_RESET = 8'h00;

  // line_status_register fields
  localparam int AST_ST_PARITY_ERROR_FLAG = 7;
  localparam int AST_ST_FRAMING_ERROR_FLAG = 6;
  localparam int AST_ST_OVERRUN_FLAG = 5;
  localparam int AST_ST_RX_BUFFER_FULL_FLAG = 4;
  localparam int AST_ST_TX_DONE_FLAG = 3;
  localparam int AST_ST_TX_BUFFER_EMPTY_FLAG = 2;

  localparam logic [7:0] AST_BUF_RESET = 8'h00;

  // rate select codes and divisors of the system clock
  localparam logic [2:0] AST_BRG_TIMER = 3'b110;
  localparam logic [8:0] AST_DIV0 = 9'd13;
  localparam logic [8:0] AST_DIV1 = 9'd26;
  localparam logic [8:0] AST_DIV2 = 9'd52;
  localparam logic [8:0] AST_DIV3 = 9'd104;
  localparam logic [8:0] AST_DIV4 = 9'd208;
  localparam logic [8:0] AST_DIV5 = 9'd416;
  localparam logic [8:0] AST_DIV7 = 9'd96;

  // oversample ticks per bit and the three voting points
  localparam logic [3:0] AST_TICK_LAST = 4'd15;
  localparam logic [3:0] AST_SAMP_A    = 4'd7;
  localparam logic [3:0] AST_SAMP_B    = 4'd8;
  localparam logic [3:0] AST_SAMP_C    = 4'd9;

  // frame bit indexes: 0 start, 1..8 data, then parity and stop bits
  localparam logic [3:0] AST_BIT_FIRST_DATA = 4'd1;
  localparam logic [3:0] AST_BIT_LAST_DATA  = 4'd8;

  typedef enum logic [0:0] {
    AST_IDLE = 1'b0,
    AST_BUSY = 1'b1
  } ast_state_t;
endpackage

// ---- verilog/ast_uart.sv ----
// asynchronous serial transceiver with apb register access
// assumes rxd_in arrives from a pin and timer_tick is a one-cycle pulse on pclk
//
// Local design decision: the APB register port.
`timescale 1ns/10ps

// Summary of operation
// RULE1 - frame is low start bit, data, optional parity, one or more high stops
// RULE2 - timer source code: timer pulses are the transfer clock, bit rate is it over sixteen
// RULE3 - rate codes 0-5 divide by 13..416, code 6 timer, code 7 divides by 96
// RULE4 - hunt for low at tick rate; vote ticks 7, 8, 9 of every bit
// RULE5 - transmitter sends one or two stop bits per stop length select
// RULE6 - parity added and checked only when enabled; odd or even, shared both ways
// RULE7 - status read then buffer write clears empty flag and starts the byte
// RULE8 - start of shifting sets empty flag and pulses the transmit interrupt
// RULE9 - serial output idles high while disabled and until first byte written
// RULE10 - buffer write without prior status read is ignored
// RULE11 - completed frame loads data only, sets full flag, pulses receive interrupt
// RULE12 - frame completing with buffer full sets overrun, new data discarded
// RULE13 - no receiving while overrun flag is set
// RULE14 - parity mismatch on received data sets parity error flag
// RULE15 - stop bit sampled low sets framing error flag
// RULE16 - receive flags clear only on buffer read after status read
// RULE17 - overrun set after the status read survives the buffer read
// RULE18 - transmit end set when done and buffer empty, cleared when next starts
// RULE19 - receive disable waits for the current frame to finish
// RULE20 - receive and transmit buffers share one address, read versus write
// RULE21 - transmit disable waits for frame end; waiting byte is dropped
// RULE22 - software disables both directions before changing the rate field
// RULE23 - eight data bits, lsb first, parity over those eight
// RULE24 - reset clears errors and full flag, sets end and empty, zeroes buffers
module ast_uart
  import ast_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ast_pkg::AST_AW-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 rxd_in,
  input  wire logic                 timer_tick,
  output logic                      txd,
  output logic                      tx_event_irq,
  output logic                      rx_event_irq
);
  import ast_pkg::*;

  function automatic logic [8:0] ast_div(input logic [2:0] code);
    logic [8:0] d;
    d = AST_DIV7;
    case (code)
      3'd0: d = AST_DIV0;
      3'd1: d = AST_DIV1;
      3'd2: d = AST_DIV2;
      3'd3: d = AST_DIV3;
      3'd4: d = AST_DIV4;
      3'd5: d = AST_DIV5;
      default: d = AST_DIV7;
    endcase
    return d;
  endfunction

  // parity bit for eight data bits; even parity makes the total count even
  function automatic logic ast_par(input logic [7:0] d, input logic even);
    return even ? (^d) : ~(^d);
  endfunction

  // ---------------- apb slave ----------------
  logic [7:0] ctrl;
  logic [7:0] rx_holding_buffer;
  logic [7:0] tx_holding_buffer;
  logic       parity_error_flag;
  logic       framing_error_flag;
  logic       overrun_flag;
  logic       rx_buffer_full_flag;
  logic       tx_done_flag;
  logic       tx_buffer_empty_flag;
  logic       rd_seen;
  logic       overrun_flag_seen;
  logic       wr_seen;
  logic       tx_pend;

  wire        acc       = psel & penable & ~pready;
  wire        done      = psel & penable & pready;
  wire        hit_st    = paddr == AST_ADDR_STATUS;
  wire        hit_ctl   = paddr == AST_ADDR_CTRL;
  wire        hit_dat   = paddr == AST_ADDR_DATA;
  wire        mapped    = hit_st | hit_ctl | hit_dat;
  wire        st_rd     = done & ~pwrite & hit_st;
  wire        dat_rd    = done & ~pwrite & hit_dat;
  wire        dat_wr    = done & pwrite & hit_dat;
  wire        ctl_wr    = done & pwrite & hit_ctl;
  wire        tx_enable_bit      = ctrl[AST_CTL_TXE];
  wire        rx_enable_bit      = ctrl[AST_CTL_RXE];
  wire        stop_length_select = ctrl[AST_CTL_STOP_LENGTH_SELECT];
  wire        parity_even        = ctrl[AST_CTL_EVEN];
  wire        parity_enable_bit  = ctrl[AST_CTL_PE];
  wire [2:0]  rate_select_field  = ctrl[AST_CTL_BRG +: 3];
  wire [7:0]  line_status = {parity_error_flag, framing_error_flag, overrun_flag,
                             rx_buffer_full_flag, tx_done_flag, tx_buffer_empty_flag,
                             2'b00};
  wire [7:0]  rd_byte = hit_st  ? line_status :
                        hit_ctl ? ctrl :
                        rx_holding_buffer;                         // [RULE20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= (acc & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= AST_CTL_RESET;
    end else if (ctl_wr) begin
      ctrl <= pwdata[7:0];                                         // [RULE22]
    end
  end

  // status-read memory for the two read-then-access sequences
  wire clr_rx = dat_rd & rd_seen;                                  // [RULE16]
  wire tx_ok  = dat_wr & wr_seen & tx_enable_bit;                  // [RULE7] [RULE10]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_seen   <= 1'b0;
      wr_seen   <= 1'b0;
      overrun_flag_seen <= 1'b0;
    end else begin
      if (st_rd) begin
        rd_seen   <= 1'b1;
        wr_seen   <= 1'b1;
        overrun_flag_seen <= overrun_flag;                                 // [RULE17]
      end else begin
        if (dat_rd) begin
          rd_seen <= 1'b0;
        end
        if (dat_wr) begin
          wr_seen <= 1'b0;
        end
      end
    end
  end

  // ---------------- transfer clock ----------------
  logic [8:0] div_cnt;
  logic       tick;
  logic [1:0] rx_sync;
  wire  [8:0] div_top  = ast_div(rate_select_field) - 9'd1;
  wire        use_tmr  = rate_select_field == AST_BRG_TIMER;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 9'd0;
      tick    <= 1'b0;
      rx_sync <= 2'b11;
    end else begin
      div_cnt <= (use_tmr || div_cnt >= div_top) ? 9'd0 : div_cnt + 9'd1; // [RULE3]
      tick    <= use_tmr ? timer_tick : (div_cnt >= div_top);      // [RULE2] [RULE3]
      rx_sync <= {rx_sync[0], rxd_in};
    end
  end

  wire rxd = rx_sync[1];

  // ---------------- transmitter ----------------
  ast_state_t tx_state;
  logic [3:0] tx_tick;
  logic [3:0] tx_bit;
  logic [8:0] tx_shift;
  wire  [3:0] tx_last = 4'd9 + {3'd0, parity_enable_bit} + {3'd0, stop_length_select};
  wire        tx_go   = tx_state == AST_IDLE && tx_pend && tx_enable_bit && tick;
  wire        tx_end  = tx_state == AST_BUSY && tick && tx_tick == AST_TICK_LAST
                        && tx_bit == tx_last;
  wire        tx_step = tx_state == AST_BUSY && tick && tx_tick == AST_TICK_LAST;
  wire        tx_par_now = parity_enable_bit && tx_bit == 4'd9;
  wire        tx_stop_now = tx_bit > AST_BIT_LAST_DATA && !tx_par_now;
  wire        next_txd = tx_state == AST_IDLE ? 1'b1 :              // [RULE9]
                         tx_bit == 4'd0     ? 1'b0 :                // [RULE1]
                         tx_stop_now        ? 1'b1 :                // [RULE5]
                         tx_shift[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= AST_IDLE;
      tx_tick  <= 4'd0;
      tx_bit   <= 4'd0;
      tx_shift <= 9'd0;
      txd      <= 1'b1;
    end else begin
      txd <= next_txd;
      if (tx_go) begin
        tx_state <= AST_BUSY;
        tx_tick  <= 4'd0;
        tx_bit   <= 4'd0;
        tx_shift <= {ast_par(tx_holding_buffer, parity_even), tx_holding_buffer}; // [RULE6]
      end else if (tx_end) begin
        tx_state <= AST_IDLE;                                      // [RULE21]
      end else if (tx_state == AST_BUSY && tick) begin
        tx_tick <= tx_tick + 4'd1;
        if (tx_step) begin
          tx_bit <= tx_bit + 4'd1;
          if (tx_bit != 4'd0) begin
            tx_shift <= {1'b1, tx_shift[8:1]};                     // [RULE23]
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_buffer    <= AST_BUF_RESET;                       // [RULE24]
      tx_pend              <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag         <= 1'b1;
      tx_event_irq         <= 1'b0;
    end else begin
      tx_event_irq <= tx_go;                                       // [RULE8]
      if (tx_ok) begin
        tx_holding_buffer    <= pwdata[7:0];
        tx_pend              <= 1'b1;
        tx_buffer_empty_flag <= 1'b0;
      end else if (tx_go) begin
        tx_pend              <= 1'b0;
        tx_buffer_empty_flag <= 1'b1;                              // [RULE8]
      end else if (tx_state == AST_IDLE && !tx_enable_bit) begin
        tx_pend <= 1'b0;                                           // [RULE21]
      end
      if (tx_go) begin
        tx_done_flag <= 1'b0;                                      // [RULE18]
      end else if (tx_end && !tx_pend && !tx_ok) begin
        tx_done_flag <= 1'b1;                                      // [RULE18]
      end
    end
  end

  // ---------------- receiver ----------------
  ast_state_t rx_state;
  logic [3:0] rx_tick;
  logic [3:0] rx_bit;
  logic [1:0] rx_votes;
  logic [8:0] rx_shift;
  wire        rx_hunt  = rx_state == AST_IDLE && tick && rx_enable_bit
                         && !overrun_flag && !rxd;                 // [RULE4] [RULE13] [RULE19]
  wire        rx_vote  = rx_state == AST_BUSY && tick && rx_tick == AST_SAMP_C;
  wire        rx_smp   = rx_state == AST_BUSY && tick
                         && (rx_tick == AST_SAMP_A || rx_tick == AST_SAMP_B);
  wire        rx_maj   = rx_votes[1] | (rx_votes[0] & rxd);        // [RULE4]
  wire [3:0]  rx_stopi = 4'd9 + {3'd0, parity_enable_bit};
  wire        rx_abort = rx_vote && rx_bit == 4'd0 && rx_maj;
  wire        rx_fin   = rx_vote && rx_bit == rx_stopi;
  wire [7:0]  rx_data  = rx_shift[7:0];
  wire        rx_parity_error_flag  = parity_enable_bit
                         && ast_par(rx_data, parity_even) != rx_shift[8]; // [RULE14]
  wire        rx_load  = rx_fin && !rx_buffer_full_flag;
  wire        rx_ovr   = rx_fin && rx_buffer_full_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= AST_IDLE;
      rx_tick  <= 4'd0;
      rx_bit   <= 4'd0;
      rx_votes <= 2'b00;
      rx_shift <= 9'd0;
    end else begin
      if (rx_hunt) begin
        rx_state <= AST_BUSY;
        rx_tick  <= 4'd1;
        rx_bit   <= 4'd0;
      end else if (rx_abort || rx_fin) begin
        rx_state <= AST_IDLE;
      end else if (rx_state == AST_BUSY && tick) begin
        rx_tick <= rx_tick + 4'd1;
        if (rx_tick == AST_TICK_LAST) begin
          rx_bit <= rx_bit + 4'd1;
        end
      end
      if (rx_smp) begin
        rx_votes <= (rx_tick == AST_SAMP_A) ? {1'b0, rxd} : {rx_votes[0] & rxd,
                                                             rx_votes[0] | rxd};
      end
      if (rx_vote && rx_bit >= AST_BIT_FIRST_DATA && rx_bit <= AST_BIT_LAST_DATA) begin
        rx_shift[7:0] <= {rx_maj, rx_shift[7:1]};                  // [RULE23]
      end
      if (rx_vote && parity_enable_bit && rx_bit == 4'd9) begin
        rx_shift[8] <= rx_maj;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding_buffer   <= AST_BUF_RESET;                        // [RULE24]
      rx_buffer_full_flag <= 1'b0;
      parity_error_flag   <= 1'b0;
      framing_error_flag  <= 1'b0;
      overrun_flag        <= 1'b0;
      rx_event_irq        <= 1'b0;
    end else begin
      rx_event_irq <= rx_load;                                     // [RULE11]
      if (rx_load) begin
        rx_holding_buffer   <= rx_data;                            // [RULE11]
        rx_buffer_full_flag <= 1'b1;
        parity_error_flag   <= rx_parity_error_flag;                            // [RULE14]
        framing_error_flag  <= !rx_maj;                            // [RULE15]
      end else if (clr_rx) begin
        rx_buffer_full_flag <= 1'b0;                               // [RULE16]
        parity_error_flag   <= 1'b0;
        framing_error_flag  <= 1'b0;
      end
      if (rx_ovr) begin
        overrun_flag <= 1'b1;                                      // [RULE12]
      end else if (clr_rx && overrun_flag_seen) begin
        overrun_flag <= 1'b0;                                      // [RULE17]
      end
    end
  end
endmodule
